//--- sbcspi_core.sv
`default_nettype none
module sbcspi_core
    import sbcspi_pkg::*;
(
    input  wire logic   mclk_in,
    input  wire logic   rst_n_in,
    input  wire logic   chip_select_n_in,
    input  wire logic   serial_clk_in,
    input  wire logic   serial_in_in,
    output logic        serial_out_out,
    output logic        serial_out_oe_out,
    input  wire logic   reset_output_n_in,
    input  wire logic   restart_done_in,
    input  wire logic   wake_in,
    input  wire sbcspi_stat_t stat_set_in,
    output sbcspi_stat_t stat_out,
    output sbcspi_cfg_s  cfg_out,
    output sbcspi_mode_e mode_out,
    output logic        wd_trigger_out,
    output logic        interrupt_out
);
    typedef struct packed {
        logic [2:0]   chip_select_n;
        logic [2:0]   sclk;
        logic [1:0]   serial_in;
        logic [15:0]  rx;
        logic [4:0]   nfall;
        logic [4:0]   nrise;
        logic         clk_hi;
        logic         ro_ovl;
        logic         err;
        logic         serial_out;
        logic [7:0]   rd;
        logic         oe;
        sbcspi_mode_e mode;
        sbcspi_cfg_s  cfg;
        sbcspi_stat_t stat;
        logic         wd_trig;
        logic         irq;
    } sbcspi_state_s;

    sbcspi_state_s s_r;
    sbcspi_state_s s_nxt;

    function automatic logic [1:0] mode_code(input sbcspi_mode_e m);
        logic [1:0] c;
        c = REQ_NORMAL;
        if (m == MODE_STOP)
            c = REQ_STOP;
        else if (m == MODE_SLEEP)
            c = REQ_SLEEP;
        return c;
    endfunction

    // byte returned for an address, status or config
    function automatic logic [7:0] read_byte(input logic [6:0]    a,
                                             input sbcspi_state_s st);
        logic [7:0] b;
        b = 8'h00;
        if (a == ADDR_MODE_CTRL)
            b = {mode_code(st.mode), st.cfg.mode_ctrl[MODE_REQ_LSB-1:0]};
        else if (a == ADDR_WATCHDOG_CONTROL)
            b = st.cfg.watchdog_control;
        else if (a == ADDR_BUS_CTRL1)
            b = st.cfg.bus_ctrl1;
        else if (a == ADDR_WAKE_CTRL2)
            b = st.cfg.wake_ctrl2;
        else if (a == ADDR_TIMER1)
            b = st.cfg.timer1;
        else if (a == ADDR_TIMER2)
            b = st.cfg.timer2;
        else if (a == ADDR_SUP_STAT2)
            b = st.stat[STAT_SUP2];
        else if (a == ADDR_SUP_STAT1)
            b = st.stat[STAT_SUP1];
        else if (a == ADDR_THERMAL_STATUS)
            b = st.stat[STAT_THRM];
        else if (a == ADDR_DEVICE_STATUS)
            b = st.stat[STAT_DEV];
        else if (a == ADDR_BUS_STAT)
            b = st.stat[STAT_BUS];
        else if (a == ADDR_WAKE_STAT1)
            b = st.stat[STAT_WK1];
        else if (a == ADDR_WAKE_STAT2)
            b = st.stat[STAT_WK2];
        else if (a == ADDR_SW_OVL)
            b = st.stat[STAT_OVL];
        else if (a == ADDR_SW_OPEN)
            b = st.stat[STAT_OPEN];
        return b;
    endfunction

    function automatic logic [STAT_NUM-1:0] stat_index(input logic [6:0] a);
        logic [STAT_NUM-1:0] m;
        m = '0;
        if (a == ADDR_SUP_STAT2)
            m[STAT_SUP2] = 1'b1;
        else if (a == ADDR_SUP_STAT1)
            m[STAT_SUP1] = 1'b1;
        else if (a == ADDR_THERMAL_STATUS)
            m[STAT_THRM] = 1'b1;
        else if (a == ADDR_DEVICE_STATUS)
            m[STAT_DEV] = 1'b1;
        else if (a == ADDR_BUS_STAT)
            m[STAT_BUS] = 1'b1;
        else if (a == ADDR_WAKE_STAT1)
            m[STAT_WK1] = 1'b1;
        else if (a == ADDR_WAKE_STAT2)
            m[STAT_WK2] = 1'b1;
        else if (a == ADDR_SW_OVL)
            m[STAT_OVL] = 1'b1;
        else if (a == ADDR_SW_OPEN)
            m[STAT_OPEN] = 1'b1;
        return m;
    endfunction

    logic                csn_fall;
    logic                csn_rise;
    logic                sclk_fall;
    logic                sclk_rise;
    logic [7:0]          summary;
    logic [15:0]         resp;
    logic [6:0]          addr;
    logic                sel;
    logic [7:0]          data;
    logic                fail;
    logic                bad;
    logic [STAT_NUM-1:0] clr;
    logic [1:0]          req;
    logic                sleep_bad;

    always_comb
    begin
        s_nxt = s_r;
        s_nxt.wd_trig = 1'b0;
        s_nxt.irq = 1'b0;
        fail = 1'b0;
        bad = 1'b0;
        clr = '0;
        req = REQ_NORMAL;
        sleep_bad = 1'b0;
        addr = s_r.rx[6:0];
        sel = s_r.rx[SEL_BIT];
        data = s_r.rx[15:DATA_LSB];

        // link pins, two flops before use, third for edges
        s_nxt.chip_select_n = {s_r.chip_select_n[1:0], chip_select_n_in};
        s_nxt.sclk = {s_r.sclk[1:0], serial_clk_in};
        s_nxt.serial_in = {s_r.serial_in[0], serial_in_in};
        csn_fall = s_r.chip_select_n[2] & ~s_r.chip_select_n[1];
        csn_rise = ~s_r.chip_select_n[2] & s_r.chip_select_n[1];
        sclk_fall = s_r.sclk[2] & ~s_r.sclk[1];
        sclk_rise = ~s_r.sclk[2] & s_r.sclk[1];

        // wake level excluded; wake pair shares one bit
        summary[0] = |s_r.stat[STAT_SUP1];
        summary[1] = |s_r.stat[STAT_THRM];
        summary[2] = |s_r.stat[STAT_DEV];
        summary[3] = |s_r.stat[STAT_BUS];
        summary[4] = |{s_r.stat[STAT_WK1], s_r.stat[STAT_WK2]};
        summary[5] = |s_r.stat[STAT_SUP2];
        summary[6] = |s_r.stat[STAT_OVL];
        summary[7] = |s_r.stat[STAT_OPEN];
        // address bits 6..0 sit at rx[14:8] after eight falling edges;
        // rx shifts on, so the byte is held from the ninth bit out
        resp[7:0] = summary;
        if (s_r.nrise > (FRAME_BITS >> 1))
            resp[15:8] = s_r.rd;
        else
            resp[15:8] = read_byte(s_r.rx[14:8], s_r);

        if (csn_fall)
        begin
            s_nxt.nfall = FRAME_NONE;
            s_nxt.nrise = FRAME_NONE;
            s_nxt.rx = 16'h0000;
            s_nxt.clk_hi = s_r.sclk[1];
            s_nxt.ro_ovl = ~reset_output_n_in;
        end
        else if (!s_r.chip_select_n[1])
        begin
            if (sclk_fall)
            begin
                s_nxt.rx = {s_r.serial_in[1], s_r.rx[15:1]};
                if (s_r.nfall != 5'h1f)
                    s_nxt.nfall = s_r.nfall + 5'h01;
            end
            if (sclk_rise && s_r.nrise != 5'h1f)
                s_nxt.nrise = s_r.nrise + 5'h01;
            if (!reset_output_n_in)
                s_nxt.ro_ovl = 1'b1;
        end

        // serial output: error first, then one bit per rising edge
        if (!reset_output_n_in)
            s_nxt.serial_out = 1'b1;
        else if (csn_fall)
            s_nxt.serial_out = s_r.err;
        else if (!s_r.chip_select_n[1] && sclk_rise && s_r.nrise < FRAME_BITS)
        begin
            s_nxt.serial_out = resp[s_r.nrise[3:0]];
            s_nxt.rd = resp[15:8];
        end
        s_nxt.oe = ~s_r.chip_select_n[1] & ~csn_rise;

        if (csn_rise)
        begin
            bad = s_r.clk_hi | s_r.sclk[1]
                | (s_r.nfall != FRAME_NONE && s_r.nfall != FRAME_BITS);
            s_nxt.err = bad | s_r.ro_ovl | ~reset_output_n_in;
            if (!s_nxt.err && s_r.nfall == FRAME_BITS
                && s_r.mode != MODE_RESTART)
            begin
                if (s_r.rx == 16'h0000 || s_r.rx == 16'hffff)
                    fail = 1'b1;
                else if (addr[STATUS_BIT])
                begin
                    if (sel)
                        clr = stat_index(addr);
                end
                else if (sel)
                begin
                    if (addr == ADDR_MODE_CTRL)
                    begin
                        req = data[7:MODE_REQ_LSB];
                        case (s_r.mode)
                            MODE_STOP:
                            begin
                                if (req == REQ_SLEEP)
                                begin
                                    fail = 1'b1;
                                    s_nxt.mode = MODE_RESTART;
                                end
                                else if (req == REQ_NORMAL)
                                begin
                                    s_nxt.mode = MODE_NORMAL;
                                    if (data[MODE_REQ_LSB-1:0]
                                        != s_r.cfg.mode_ctrl[MODE_REQ_LSB-1:0])
                                        fail = 1'b1;
                                end
                                else if (req == REQ_RESET)
                                    s_nxt.mode = MODE_RESTART;
                            end
                            MODE_INIT:
                            begin
                                if (req == REQ_RESET)
                                    s_nxt.mode = MODE_RESTART;
                                else
                                begin
                                    s_nxt.mode = MODE_NORMAL;
                                    if (req != REQ_NORMAL)
                                        fail = 1'b1;
                                    s_nxt.cfg.mode_ctrl[MODE_REQ_LSB-1:0] =
                                        data[MODE_REQ_LSB-1:0];
                                end
                            end
                            default:
                            begin
                                s_nxt.cfg.mode_ctrl[MODE_REQ_LSB-1:0] =
                                    data[MODE_REQ_LSB-1:0];
                                if (req == REQ_RESET)
                                    s_nxt.mode = MODE_RESTART;
                                else if (req == REQ_STOP)
                                begin
                                    s_nxt.mode = MODE_STOP;
                                    if (|{s_r.stat[STAT_WK1],
                                          s_r.stat[STAT_WK2]})
                                        s_nxt.irq = 1'b1;
                                end
                                else if (req == REQ_SLEEP)
                                begin
                                    sleep_bad = (s_r.cfg.bus_ctrl1 == 8'h00
                                        && s_r.cfg.wake_ctrl2 == 8'h00);
                                    if (s_r.cfg.wake_ctrl2[WAKE_PIN_MEASUREMENT_BIT]
                                        && s_r.cfg.bus_ctrl1 == 8'h00
                                        && (s_r.cfg.wake_ctrl2[WAKE_INPUT_ONE_ENABLE_BIT]
                                            | s_r.cfg.wake_ctrl2[WAKE_INPUT_TWO_ENABLE_BIT])
                                        && s_r.cfg.wake_ctrl2[7:3] == 5'h00)
                                        sleep_bad = 1'b1;
                                    fail = sleep_bad;
                                    s_nxt.mode = sleep_bad ? MODE_RESTART
                                                           : MODE_SLEEP;
                                end
                                else
                                    s_nxt.mode = MODE_NORMAL;
                            end
                        endcase
                        // load sharing cannot be cleared once set
                        if (s_r.cfg.mode_ctrl[LOAD_SHARE])
                            s_nxt.cfg.mode_ctrl[LOAD_SHARE] = 1'b1;
                    end
                    else if (addr == ADDR_WATCHDOG_CONTROL)
                    begin
                        if (^data)
                            fail = 1'b1;
                        else
                        begin
                            s_nxt.cfg.watchdog_control = data;
                            s_nxt.wd_trig = 1'b1;
                        end
                    end
                    else if (s_r.mode == MODE_STOP)
                        fail = 1'b1;
                    else if (addr == ADDR_BUS_CTRL1)
                        s_nxt.cfg.bus_ctrl1 = data;
                    else if (addr == ADDR_WAKE_CTRL2)
                        s_nxt.cfg.wake_ctrl2 = data;
                    else if (addr == ADDR_TIMER1 || addr == ADDR_TIMER2)
                    begin
                        if (data[6:TMR_ON_LSB]
                            >= data[TMR_ON_LSB-2:TMR_PER_LSB])
                            fail = 1'b1;
                        else if (addr == ADDR_TIMER1)
                            s_nxt.cfg.timer1 = data;
                        else
                            s_nxt.cfg.timer2 = data;
                    end
                end
            end
        end

        // mode exits driven by the rest of the device
        if (s_r.mode == MODE_RESTART && restart_done_in)
            s_nxt.mode = MODE_INIT;
        else if (s_r.mode == MODE_SLEEP && wake_in)
            s_nxt.mode = MODE_RESTART;

        // hardware set wins over a clear in the same cycle
        for (int i = 0; i < STAT_NUM; i++)
            s_nxt.stat[i] = (s_r.stat[i] & ~{8{clr[i]}}) | stat_set_in[i];
        if (fail)
            s_nxt.stat[STAT_DEV][SPI_FAIL_BIT] = 1'b1;
    end

    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in)
        begin
            s_r.chip_select_n <= 3'h7;
            s_r.sclk <= 3'h0;
            s_r.serial_in <= 2'h0;
            s_r.rx <= 16'h0000;
            s_r.nfall <= FRAME_NONE;
            s_r.nrise <= FRAME_NONE;
            s_r.clk_hi <= 1'b0;
            s_r.ro_ovl <= 1'b0;
            s_r.err <= 1'b0;
            s_r.serial_out <= 1'b1;
            s_r.rd <= 8'h00;
            s_r.oe <= 1'b0;
            s_r.mode <= MODE_INIT;
            s_r.cfg <= {MODE_CTRL_RST, WATCHDOG_CONTROL_RST, BUS_CTRL_RST,
                        WAKE_CTRL_RST, TIMER_RST, TIMER_RST};
            s_r.stat <= {STAT_NUM{STAT_RST}};
            s_r.wd_trig <= 1'b0;
            s_r.irq <= 1'b0;
        end
        else
            s_r <= s_nxt;
    end

    assign serial_out_out = s_r.serial_out;
    assign serial_out_oe_out = s_r.oe;
    assign stat_out = s_r.stat;
    assign cfg_out = s_r.cfg;
    assign mode_out = s_r.mode;
    assign wd_trigger_out = s_r.wd_trig;
    assign interrupt_out = s_r.irq;
endmodule
`default_nettype wire

//--- sbcspi_pkg.sv
`default_nettype none
package sbcspi_pkg;
    localparam logic [4:0] FRAME_BITS      = 5'h10;
    localparam logic [4:0] FRAME_NONE      = 5'h00;
    localparam int         SEL_BIT         = 7;
    localparam int         DATA_LSB        = 8;
    localparam int         STATUS_BIT      = 6;
    // control registers
    localparam logic [6:0] ADDR_MODE_CTRL  = 7'h01;
    localparam logic [6:0] ADDR_WATCHDOG_CONTROL    = 7'h03;
    localparam logic [6:0] ADDR_BUS_CTRL1  = 7'h04;
    localparam logic [6:0] ADDR_WAKE_CTRL2 = 7'h07;
    localparam logic [6:0] ADDR_TIMER1     = 7'h0c;
    localparam logic [6:0] ADDR_TIMER2     = 7'h0d;
    // status registers
    localparam logic [6:0] ADDR_SUP_STAT2  = 7'h40;
    localparam logic [6:0] ADDR_SUP_STAT1  = 7'h41;
    localparam logic [6:0] ADDR_THERMAL_STATUS = 7'h42;
    localparam logic [6:0] ADDR_DEVICE_STATUS   = 7'h43;
    localparam logic [6:0] ADDR_BUS_STAT   = 7'h44;
    localparam logic [6:0] ADDR_WAKE_STAT1 = 7'h46;
    localparam logic [6:0] ADDR_WAKE_STAT2 = 7'h47;
    localparam logic [6:0] ADDR_SW_OVL     = 7'h54;
    localparam logic [6:0] ADDR_SW_OPEN    = 7'h55;
    // status array index
    localparam int STAT_SUP2 = 0;
    localparam int STAT_SUP1 = 1;
    localparam int STAT_THRM = 2;
    localparam int STAT_DEV  = 3;
    localparam int STAT_BUS  = 4;
    localparam int STAT_WK1  = 5;
    localparam int STAT_WK2  = 6;
    localparam int STAT_OVL  = 7;
    localparam int STAT_OPEN = 8;
    localparam int STAT_NUM  = 9;
    // field positions
    localparam int MODE_REQ_LSB  = 6;
    localparam int LOAD_SHARE    = 0;
    localparam int WAKE_INPUT_ONE_ENABLE_BIT    = 0;
    localparam int WAKE_INPUT_TWO_ENABLE_BIT    = 1;
    localparam int WAKE_PIN_MEASUREMENT_BIT   = 2;
    localparam int TMR_ON_LSB    = 4;
    localparam int TMR_PER_LSB   = 0;
    localparam int SPI_FAIL_BIT  = 2;
    // mode request codes
    localparam logic [1:0] REQ_NORMAL = 2'h0;
    localparam logic [1:0] REQ_SLEEP  = 2'h1;
    localparam logic [1:0] REQ_STOP   = 2'h2;
    localparam logic [1:0] REQ_RESET  = 2'h3;
    // reset values
    localparam logic [7:0] MODE_CTRL_RST = 8'h00;
    localparam logic [7:0] WATCHDOG_CONTROL_RST   = 8'h00;
    localparam logic [7:0] BUS_CTRL_RST  = 8'h00;
    localparam logic [7:0] WAKE_CTRL_RST = 8'h00;
    localparam logic [7:0] TIMER_RST     = 8'h00;
    localparam logic [7:0] STAT_RST      = 8'h00;

    typedef enum logic [4:0] {
        MODE_INIT    = 5'h01,
        MODE_NORMAL  = 5'h02,
        MODE_STOP    = 5'h04,
        MODE_SLEEP   = 5'h08,
        MODE_RESTART = 5'h10
    } sbcspi_mode_e;

    typedef logic [STAT_NUM-1:0][7:0] sbcspi_stat_t;

    typedef struct packed {
        logic [7:0] mode_ctrl;
        logic [7:0] watchdog_control;
        logic [7:0] bus_ctrl1;
        logic [7:0] wake_ctrl2;
        logic [7:0] timer1;
        logic [7:0] timer2;
    } sbcspi_cfg_s;
endpackage
`default_nettype wire

//--- sbcspi_core_asserts.sv
`default_nettype none
module sbcspi_core_checker
    import sbcspi_pkg::*;
(
    input wire logic   mclk_in,
    input wire logic   rst_n_in,
    input wire logic   chip_select_n_in,
    input wire logic   serial_clk_in,
    input wire logic   serial_in_in,
    input wire logic   serial_out_out,
    input wire logic   serial_out_oe_out,
    input wire logic   reset_output_n_in,
    input wire logic   restart_done_in,
    input wire logic   wake_in,
    input var  sbcspi_stat_t stat_set_in,
    input var  sbcspi_stat_t stat_out,
    input var  sbcspi_cfg_s  cfg_out,
    input var  sbcspi_mode_e mode_out,
    input wire logic   wd_trigger_out,
    input wire logic   interrupt_out
);
    default clocking @(posedge mclk_in);
    endclocking
    default disable iff (!rst_n_in);

    sequence s_sel_idle;
        chip_select_n_in [*5];
    endsequence
    sequence s_sel_busy;
        !chip_select_n_in [*5];
    endsequence
    sequence s_ro_low;
        !reset_output_n_in [*4];
    endsequence

    property p_oe_off;
        s_sel_idle |-> !serial_out_oe_out;
    endproperty
    property p_oe_on;
        s_sel_busy |-> serial_out_oe_out;
    endproperty
    property p_sdo_ro;
        s_ro_low |-> serial_out_out;
    endproperty
    property p_wd_par;
        wd_trigger_out |-> !(^cfg_out.watchdog_control);
    endproperty
    property p_timer;
        $changed(cfg_out.timer1) && cfg_out.timer1 != 8'h00
            |-> cfg_out.timer1[6:4] < cfg_out.timer1[2:0];
    endproperty
    property p_int_stop;
        interrupt_out |-> mode_out == MODE_STOP
            && (|stat_out[STAT_WK1] || |stat_out[STAT_WK2])
            && !$rose(stat_out[STAT_DEV][SPI_FAIL_BIT]);
    endproperty
    property p_stop_exit;
        $past(mode_out) == MODE_STOP && mode_out != MODE_STOP
            |-> mode_out inside {MODE_NORMAL, MODE_RESTART};
    endproperty
    property p_init_exit;
        $past(mode_out) == MODE_INIT && mode_out != MODE_INIT
            |-> mode_out inside {MODE_NORMAL, MODE_RESTART};
    endproperty
    property p_restart_exit;
        $past(mode_out) == MODE_RESTART && mode_out != MODE_RESTART
            |-> mode_out == MODE_INIT && $past(restart_done_in);
    endproperty
    property p_mode_at_end;
        $changed(mode_out)
            |-> chip_select_n_in || $past(restart_done_in) || $past(wake_in);
    endproperty
    property p_fail_sticky;
        $fell(stat_out[STAT_DEV][SPI_FAIL_BIT]) |-> chip_select_n_in;
    endproperty

    a_oe_off: assert property (p_oe_off)
        else $error("output enable high while deselected");
    a_oe_on: assert property (p_oe_on)
        else $error("output enable low during frame");
    a_sdo_ro: assert property (p_sdo_ro)
        else $error("serial output not high while reset output low");
    a_wd_par: assert property (p_wd_par)
        else $error("watchdog trigger with odd parity");
    a_timer: assert property (p_timer)
        else $error("timer on time not below period");
    a_int_stop: assert property (p_int_stop)
        else $error("interrupt without stop entry and pending wake");
    a_stop_exit: assert property (p_stop_exit)
        else $error("stop left for a wrong mode");
    a_init_exit: assert property (p_init_exit)
        else $error("init left for a wrong mode");
    a_restart_exit: assert property (p_restart_exit)
        else $error("restart left without restart done");
    a_mode_at_end: assert property (p_mode_at_end)
        else $error("mode changed inside a frame");
    a_fail_sticky: assert property (p_fail_sticky)
        else $error("fail flag dropped inside a frame");
endmodule

bind sbcspi_core sbcspi_core_checker sbcspi_core_checker_inst (
    .mclk_in, .rst_n_in, .chip_select_n_in, .serial_clk_in, .serial_in_in,
    .serial_out_out, .serial_out_oe_out, .reset_output_n_in,
    .restart_done_in, .wake_in, .stat_set_in, .stat_out, .cfg_out,
    .mode_out, .wd_trigger_out, .interrupt_out);
`default_nettype wire

//--- sbcspi_master.sv
`default_nettype none
module sbcspi_master (
    input  wire logic mclk_in,
    input  wire logic serial_out_in,
    output var  logic chip_select_n_out,
    output var  logic serial_clk_out,
    output var  logic serial_in_out
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HALF = 20;

    initial
    begin
        chip_select_n_out = 1'b1;
        serial_clk_out = 1'b0;
        serial_in_out = 1'b0;
    end

    task automatic frame(input logic [15:0] tx, input int nclk,
                         output logic err, output logic [15:0] rx);
        rx = 16'h0000;
        @(negedge mclk_in);
        chip_select_n_out <= 1'b0;
        repeat (HALF) @(negedge mclk_in);
        err = serial_out_in;
        for (int k = 0; k < nclk; k++)
        begin
            serial_clk_out <= 1'b1;
            serial_in_out <= tx[k];
            repeat (HALF) @(negedge mclk_in);
            rx[k] = serial_out_in;
            serial_clk_out <= 1'b0;
            repeat (HALF) @(negedge mclk_in);
        end
        chip_select_n_out <= 1'b1;
        // released line shows no stale bit
        serial_in_out <= ~serial_in_out;
        repeat (HALF) @(negedge mclk_in);
    endtask
endmodule
`default_nettype wire

//--- tb_sbc_spi_command_interface.sv
`default_nettype none
module tb_sbc_spi_command_interface
    import sbcspi_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [6:0] SADR [STAT_NUM] = '{ADDR_SUP_STAT2,
        ADDR_SUP_STAT1, ADDR_THERMAL_STATUS, ADDR_DEVICE_STATUS, ADDR_BUS_STAT,
        ADDR_WAKE_STAT1, ADDR_WAKE_STAT2, ADDR_SW_OVL, ADDR_SW_OPEN};
    localparam int SBIT [STAT_NUM] = '{5, 0, 1, 2, 3, 4, 4, 6, 7};
    logic mclk, rst_n, ro_n, rdone, wake, chip_select_n, sclk, serial_in, serial_out, oe;
    logic wd_trig, intr, err;
    logic [15:0] rx;
    sbcspi_stat_t stat_set, stat;
    sbcspi_cfg_s cfg;
    sbcspi_mode_e mode;
    int mismatches, n_compared, cycles, n_wd, n_int;

    sbcspi_core sbcspi_core_inst (
        .mclk_in(mclk), .rst_n_in(rst_n), .chip_select_n_in(chip_select_n),
        .serial_clk_in(sclk), .serial_in_in(serial_in), .serial_out_out(serial_out),
        .serial_out_oe_out(oe), .reset_output_n_in(ro_n),
        .restart_done_in(rdone), .wake_in(wake), .stat_set_in(stat_set),
        .stat_out(stat), .cfg_out(cfg), .mode_out(mode),
        .wd_trigger_out(wd_trig), .interrupt_out(intr));
    sbcspi_master sbcspi_master_inst (
        .mclk_in(mclk), .serial_out_in(serial_out), .chip_select_n_out(chip_select_n),
        .serial_clk_out(sclk), .serial_in_out(serial_in));

    always #2 mclk = ~mclk;

    always @(posedge mclk)
    begin
        cycles++;
        if (wd_trig === 1'b1) n_wd++;
        if (intr === 1'b1) n_int++;
        if (cycles == 60000)
        begin
            mismatches++;
            report_and_stop();
        end
    end

    task automatic chk(input string what, input logic [15:0] seen, exp);
        n_compared++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("BAD %s exp %h seen %h", what, exp, seen);
        end
    endtask
    function automatic logic [15:0] w(logic [6:0] a, logic [7:0] d);
        return {d, 1'b1, a};
    endfunction
    task automatic xfer(input logic [15:0] tx, input int n = 16);
        sbcspi_master_inst.frame(tx, n, err, rx);
    endtask
    task automatic fail(input logic exp);
        chk("fail", 16'(stat[STAT_DEV][SPI_FAIL_BIT]), 16'(exp));
    endtask
    task automatic clr();
        xfer(w(ADDR_DEVICE_STATUS, 8'h00));
        fail(1'b0);
    endtask
    task automatic md(input sbcspi_mode_e m);
        chk("mode", 16'(mode), 16'(m));
    endtask
    task automatic to_normal();
        rdone <= 1'b1;
        @(negedge mclk);
        rdone <= 1'b0;
        clr();
        xfer(w(ADDR_MODE_CTRL, 8'h00));
        md(MODE_NORMAL);
    endtask
    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial
    begin
        mclk = 0; rst_n = 0; ro_n = 1; rdone = 0; wake = 0;
        stat_set = '0;
        repeat (10) @(negedge mclk);
        rst_n <= 1'b1;
        repeat (4) @(negedge mclk);
        md(MODE_INIT);
        for (int i = 0; i < STAT_NUM; i++)
        begin
            stat_set[i] <= 8'h80;
            @(negedge mclk);
            stat_set <= '0;
            xfer(w(SADR[i], 8'h00));
            chk("sum", rx, {8'h80, 8'(1 << SBIT[i])});
            chk("rc", 16'(stat[i]), 16'h0000);
        end
        xfer(w(ADDR_WATCHDOG_CONTROL, 8'h03));
        chk("wd_old", 16'(rx[15:8]), 16'h0000);
        chk("wd", 16'(cfg.watchdog_control), 16'h0003);
        chk("wd_n", 16'(n_wd), 16'h0001);
        xfer({8'h00, 1'b0, ADDR_WATCHDOG_CONTROL});
        chk("wd_rd", 16'(rx[15:8]), 16'h0003);
        xfer(w(ADDR_WATCHDOG_CONTROL, 8'h01));
        chk("wd_bad", 16'(cfg.watchdog_control), 16'h0003);
        chk("wd_n", 16'(n_wd), 16'h0001);
        xfer({8'h00, 1'b0, ADDR_DEVICE_STATUS});
        chk("dev_rd", rx, 16'h0404);
        fail(1'b1);
        clr();
        xfer(w(ADDR_MODE_CTRL, 8'h80));
        md(MODE_NORMAL);
        fail(1'b1);
        clr();
        stat_set[STAT_WK1] <= 8'h01;
        @(negedge mclk);
        stat_set <= '0;
        xfer(w(ADDR_MODE_CTRL, 8'h80));
        md(MODE_STOP);
        chk("int_n", 16'(n_int), 16'h0001);
        fail(1'b0);
        xfer(w(ADDR_BUS_CTRL1, 8'h01));
        chk("bus", 16'(cfg.bus_ctrl1), 16'h0000);
        fail(1'b1);
        clr();
        xfer(w(ADDR_WATCHDOG_CONTROL, 8'h05));
        chk("wd_n", 16'(n_wd), 16'h0002);
        xfer(w(ADDR_MODE_CTRL, 8'h04));
        md(MODE_NORMAL);
        chk("mctl", 16'(cfg.mode_ctrl), 16'h0000);
        fail(1'b1);
        clr();
        xfer(w(ADDR_MODE_CTRL, 8'h80));
        xfer(w(ADDR_MODE_CTRL, 8'h40));
        md(MODE_RESTART);
        fail(1'b1);
        xfer(w(ADDR_WATCHDOG_CONTROL, 8'h06));
        chk("wd_n", 16'(n_wd), 16'h0002);
        rdone <= 1'b1;
        @(negedge mclk);
        rdone <= 1'b0;
        repeat (3) @(negedge mclk);
        md(MODE_INIT);
        clr();
        xfer(w(ADDR_TIMER1, 8'h32));
        chk("tmr_bad", 16'(cfg.timer1), 16'h0000);
        fail(1'b1);
        clr();
        xfer(w(ADDR_TIMER1, 8'h23));
        chk("tmr", 16'(cfg.timer1), 16'h0023);
        fail(1'b0);
        xfer(16'hffff);
        fail(1'b1);
        clr();
        xfer(16'h0000);
        fail(1'b1);
        clr();
        xfer(w(ADDR_TIMER2, 8'h12), 8);
        chk("tmr2", 16'(cfg.timer2), 16'h0000);
        xfer(16'h0000, 0);
        chk("err", 16'(err), 16'h0001);
        xfer({8'h00, 1'b0, ADDR_TIMER2});
        chk("err0", 16'(err), 16'h0000);
        ro_n <= 1'b0;
        xfer({8'h00, 1'b0, ADDR_TIMER2});
        ro_n <= 1'b1;
        xfer({8'h00, 1'b0, ADDR_TIMER2});
        chk("err_ro", 16'(err), 16'h0001);
        to_normal();
        xfer(w(ADDR_MODE_CTRL, 8'h42));
        md(MODE_RESTART);
        fail(1'b1);
        chk("mctl_slp", 16'(cfg.mode_ctrl), 16'h0002);
        to_normal();
        xfer(w(ADDR_WAKE_CTRL2, 8'h05));
        xfer(w(ADDR_MODE_CTRL, 8'h40));
        md(MODE_RESTART);
        fail(1'b1);
        to_normal();
        xfer(w(ADDR_WAKE_CTRL2, 8'h01));
        xfer(w(ADDR_MODE_CTRL, 8'h40));
        md(MODE_SLEEP);
        fail(1'b0);
        wake <= 1'b1;
        @(negedge mclk);
        wake <= 1'b0;
        repeat (3) @(negedge mclk);
        md(MODE_RESTART);
        to_normal();
        xfer(w(ADDR_MODE_CTRL, 8'hc0));
        md(MODE_RESTART);
        report_and_stop();
    end
endmodule
`default_nettype wire
